/* File: rtl/aoc_audio_out.sv */
/*
  Audio output control: serial command intake, channel routing,
  zero-cross and immediate muting, soft-ramped attenuators, level
  and peak meters and the 96-bit meter readout on the subcode line.
  Assumes the PCM source and subcode decoder run on core_clk_i and
  the host clocks the readout link through reset and for two edges after it, otherwise only during readouts.
*/
`timescale 1ns/1ps
`default_nettype none
`include "aoc_regs.svh"

// Overview of operation
// - Play-mode nibble routes each DAC channel
// - Left plus right output is halved sum
// - Command mute mutes, clears peak; fixed cut
// - Six conditions each force the output mute
// - First four mute at zero cross, 1ms limit
// - Meter select picks normal, level or peak
// - Readout: 80 Q bits, 16 meter bits
// - Channel flag high for left, low right
// - Level readout clears maximum, flips flag
// - Peak held; cleared by normal mode, mute
// - Peak mode holds absolute time after maximum
// - Peak mode flag bit reads zero
// - Peak mode interpolated samples count silent
// - Sense source bit reroutes serial out, clock
// - Eight-bit attenuation code per channel
// - Gain is code over 255, FF unity
// - Common attenuation uses channel one code
// - Full swing ramps over 1024 samples
// - New target ramps from present gain
module aoc_audio_out #(
  parameter int unsigned GFS_CYCLES = `AOC_GFS_MS * `AOC_CLK_KHZ,
  parameter int unsigned ZC_CYCLES = `AOC_ZC_MS * `AOC_CLK_KHZ
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic cmd_clk_i,
  input wire logic cmd_data_i,
  input wire logic cmd_latch_i,
  input wire logic mute_pin_i,
  input wire logic digital_out_enable_pin_i,
  input wire logic frame_sync_good_i,
  input wire logic dout_mute_flag_i,
  input wire logic normal_speed_i,
  input wire logic sample_valid_i,
  input wire aoc_pkg::aoc_stereo_t sample_i,
  input wire logic sample_interp_i,
  input wire logic subq_valid_i,
  input wire logic [`AOC_Q_BITS-1:0] subq_data_i,
  input wire logic sense_status_i,
  input wire logic subcode_readout_clock_i,
  input wire logic sense_readout_clock_i,
  output aoc_pkg::aoc_dac_t dac_o,
  output logic dac_valid_o,
  output logic mute_active_o,
  output logic c2_double_corr_o,
  output logic crystal_rate_select_o,
  output logic subcode_serial_out_o,
  output logic sense_monitor_out_o
);
  import aoc_pkg::*;

  localparam int GW = $clog2(GFS_CYCLES + 1);
  localparam int ZW = $clog2(ZC_CYCLES + 1);
  localparam int NS = 8;
  localparam int S_CCLK = 0;
  localparam int S_CDAT = 1;
  localparam int S_CLAT = 2;
  localparam int S_MUTE = 3;
  localparam int S_DOUT = 4;
  localparam int S_GFS = 5;
  localparam int S_DONE = 6;
  localparam int S_BUSY = 7;

  // Absolute value clipped to 15 bits
  function automatic logic [14:0] abs15(input logic signed [15:0] x);
    logic [15:0] n;
    n = 16'(-x);
    abs15 = x[15] ? (n[15] ? `AOC_PCM_MAX : n[14:0]) : x[14:0];
  endfunction

  // Channel source select
  function automatic logic signed [15:0] route(input aoc_route_t sel,
      input logic signed [15:0] l, input logic signed [15:0] r);
    logic signed [16:0] sum;
    sum = 17'(l) + 17'(r);
    unique case (sel)
      AOC_RT_MUTE: route = 16'sh0000;
      AOC_RT_LEFT: route = l;
      AOC_RT_RIGHT: route = r;
      AOC_RT_SUM: route = sum[16:1];
    endcase
  endfunction

  // Meter bits sent least significant first
  function automatic logic [14:0] rev15(input logic [14:0] x);
    for (int i = 0; i < 15; i++) begin
      rev15[i] = x[14 - i];
    end
  endfunction

  logic done_tgl;
  logic lbusy;
  logic [NS-1:0] sy1, sy2, sy3, stab, stab_q;
  logic [NS-1:0] raw;

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  assign raw = {lbusy, done_tgl, frame_sync_good_i,
                digital_out_enable_pin_i, mute_pin_i, cmd_latch_i,
                cmd_data_i, cmd_clk_i};

  // Three stages; a level counts once stages two and three agree
  always_ff @(posedge core_clk_i) begin
    sy1 <= raw;
    sy2 <= sy1;
    sy3 <= sy2;
    if (sys_rst_i) begin
      stab <= {NS{1'b0}};
      stab_q <= {NS{1'b0}};
    end else begin
      stab <= (sy2 & sy3) | (stab & (sy2 ^ sy3));
      stab_q <= stab;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Serial command intake

  logic [`AOC_CMD_BITS-1:0] cmd_sh;
  logic [4:0] cmd_cnt;
  aoc_audio_ctrl_t actrl;
  aoc_mode_ctrl_t mctrl;

  wire logic clk_rise = stab[S_CCLK] & ~stab_q[S_CCLK];
  wire logic lat_rise = stab[S_CLAT] & ~stab_q[S_CLAT];
  wire logic cmd_full = cmd_cnt == 5'(`AOC_CMD_BITS);
  wire logic [3:0] cmd_addr = cmd_sh[`AOC_ADDR_MSB:`AOC_ADDR_LSB];
  wire logic wr_audio = lat_rise & cmd_full & (cmd_addr == `AOC_ADDR_AUDIO);
  wire logic wr_mode = lat_rise & cmd_full & (cmd_addr == `AOC_ADDR_MODE);

  // Shift in on clock rise, count bits up to a full word
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || lat_rise) begin
      cmd_cnt <= 5'h00;
      if (sys_rst_i) begin
        cmd_sh <= {`AOC_CMD_BITS{1'b0}};
      end
    end else if (clk_rise) begin
      cmd_sh <= {cmd_sh[`AOC_CMD_BITS-2:0], stab[S_CDAT]};
      if (!cmd_full) begin
        cmd_cnt <= cmd_cnt + 5'h01;
      end
    end
  end

  aoc_audio_ctrl_t next_actrl;
  aoc_mode_ctrl_t next_mctrl;

  // Field decode of the two command words
  assign next_actrl.mute = cmd_sh[`AOC_BIT_MUTE];
  assign next_actrl.fixed_cut_select = cmd_sh[`AOC_BIT_CUT];
  assign next_actrl.meter_mode = aoc_meter_t'({cmd_sh[`AOC_BIT_MSEL_HI],
                                              cmd_sh[`AOC_BIT_MSEL_LO]});
  assign next_actrl.crystal_rate_select = cmd_sh[`AOC_BIT_XTAL];
  assign next_actrl.sense_output_source = cmd_sh[`AOC_BIT_SENSE];
  assign next_actrl.channel1_atten_data =
      cmd_sh[`AOC_ATT1_MSB:`AOC_ATT1_LSB];
  assign next_actrl.channel2_atten_data =
      cmd_sh[`AOC_ATT2_MSB:`AOC_ATT2_LSB];
  assign next_mctrl.bilingual_main_select = cmd_sh[`AOC_BIT_BILI_MAIN];
  assign next_mctrl.bilingual_sub_select = cmd_sh[`AOC_BIT_BILI_SUB];
  assign next_mctrl.common_atten_select = cmd_sh[`AOC_BIT_COMMON_ATT];
  assign next_mctrl.ch2 = aoc_route_t'(
      cmd_sh[`AOC_PLM_CH2_MSB:`AOC_PLM_CH2_LSB]);
  assign next_mctrl.ch1 = aoc_route_t'(
      cmd_sh[`AOC_PLM_CH1_MSB:`AOC_PLM_CH1_LSB]);

  // Settings load only on a latch after a full word
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      actrl <= '{mute: 1'b0, fixed_cut_select: 1'b0,
                 meter_mode: AOC_MTR_NORMAL, crystal_rate_select: 1'b0,
                 sense_output_source: 1'b0,
                 channel1_atten_data: `AOC_ATT_RESET,
                 channel2_atten_data: `AOC_ATT_RESET};
      mctrl <= '{bilingual_main_select: 1'b0, bilingual_sub_select: 1'b0,
                 common_atten_select: 1'b0,
                 ch2: aoc_route_t'(`AOC_ROUTE_CH2_RESET),
                 ch1: aoc_route_t'(`AOC_ROUTE_CH1_RESET)};
    end else begin
      if (wr_audio) begin
        actrl <= next_actrl;
      end
      if (wr_mode) begin
        mctrl <= next_mctrl;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mute conditions

  logic [GW-1:0] gfs_cnt;
  logic [ZW-1:0] zc_cnt;
  aoc_zc_t zc_st, next_zc_st;
  logic zc_evt;

  wire logic peak_mode = actrl.meter_mode == AOC_MTR_PEAK;
  wire logic gfs_lost = gfs_cnt == GW'(GFS_CYCLES);
  wire logic zc_req = actrl.mute | stab[S_MUTE] |
                      (dout_mute_flag_i & stab[S_DOUT]) | gfs_lost;
  wire logic imm_mute = (mctrl.bilingual_main_select &
                         mctrl.bilingual_sub_select) | peak_mode;
  wire logic zc_limit = zc_cnt == ZW'(ZC_CYCLES);
  wire logic zc_muted = zc_st == AOC_ZC_MUTED || zc_st == AOC_ZC_RELEASE;
  wire logic out_mute = zc_muted | imm_mute;

  // Frame sync loss timer, normal speed only
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || stab[S_GFS] || !normal_speed_i) begin
      gfs_cnt <= {GW{1'b0}};
    end else if (!gfs_lost) begin
      gfs_cnt <= gfs_cnt + GW'(1);
    end
  end

  // Zero-cross mute sequencing with time limit
  always_comb begin
    next_zc_st = zc_st;
    unique case (zc_st)
      AOC_ZC_OPEN: if (zc_req) begin
        next_zc_st = AOC_ZC_MUTING;
      end
      AOC_ZC_MUTING: if (!zc_req) begin
        next_zc_st = AOC_ZC_OPEN;
      end else if (zc_evt || zc_limit) begin
        next_zc_st = AOC_ZC_MUTED;
      end
      AOC_ZC_MUTED: if (!zc_req) begin
        next_zc_st = AOC_ZC_RELEASE;
      end
      AOC_ZC_RELEASE: if (zc_req) begin
        next_zc_st = AOC_ZC_MUTED;
      end else if (zc_evt || zc_limit) begin
        next_zc_st = AOC_ZC_OPEN;
      end
    endcase
  end

  // State and limit counter
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      zc_st <= AOC_ZC_OPEN;
      zc_cnt <= {ZW{1'b0}};
    end else begin
      zc_st <= next_zc_st;
      if (next_zc_st != zc_st || !zc_st[0]) begin
        zc_cnt <= {ZW{1'b0}};
      end else if (!zc_limit) begin
        zc_cnt <= zc_cnt + ZW'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Channels: routing, fixed cut, soft-ramped attenuation

  logic signed [15:0] ch_next [2];
  logic [1:0] ch_cross;

  assign zc_evt = |ch_cross;

  for (genvar g = 0; g < 2; g++) begin : g_ch
    logic signed [15:0] routed, prev, cut;
    logic [17:0] level, target;
    logic [18:0] up, down;
    logic [7:0] code;
    logic signed [34:0] prod;
    aoc_route_t sel;

    assign sel = g == 0 ? mctrl.ch1 : mctrl.ch2;
    assign routed = route(sel, sample_i.left, sample_i.right);
    assign ch_cross[g] = sample_valid_i &
                         (routed == 16'sh0000 || routed[15] != prev[15]);
    assign code = (g == 0 || mctrl.common_atten_select) ?
                  actrl.channel1_atten_data :
                  actrl.channel2_atten_data;
    assign target = 18'(code * `AOC_LVL_SCALE);
    assign up = {1'b0, level} + `AOC_LVL_STEP;
    assign down = {1'b0, level} - `AOC_LVL_STEP;
    assign cut = actrl.fixed_cut_select ?
                 (routed >>> `AOC_CUT_SHIFT) : routed;
    assign prod = cut * $signed({1'b0, level});
    assign ch_next[g] = out_mute ? 16'sh0000 :
                        (level == `AOC_LVL_FULL) ? cut :
                        prod[33:`AOC_LVL_FRAC];

    // Gain steps toward target once per sample
    always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
        level <= `AOC_LVL_FULL;
        prev <= 16'sh0000;
      end else if (sample_valid_i) begin
        prev <= routed;
        if (level < target) begin
          level <= (up[18] || up[17:0] > target) ? target :
                   up[17:0];
        end else if (level > target) begin
          level <= (down[18] || down[17:0] < target) ? target :
                   down[17:0];
        end
      end
    end
  end

  // Registered DAC output
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      dac_o <= '0;
      dac_valid_o <= 1'b0;
    end else begin
      dac_valid_o <= sample_valid_i;
      if (sample_valid_i) begin
        dac_o <= '{ch1: ch_next[0], ch2: ch_next[1]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Level and peak meters

  logic [14:0] mtr_max;
  logic mtr_flag;
  logic abs_pend;
  logic [`AOC_Q_BITS-1:0] q_reg;
  logic [`AOC_ABS_BITS-1:0] abs_hold;
  logic [`AOC_READ_BITS-1:0] snap;

  wire logic done_evt = stab[S_DONE] ^ stab_q[S_DONE];
  wire logic level_mode = actrl.meter_mode == AOC_MTR_LEVEL;
  wire logic [14:0] mag_l = abs15(sample_i.left);
  wire logic [14:0] mag_r = abs15(sample_i.right);
  wire logic [14:0] mag_pk = sample_interp_i ? 15'h0000 :
                     (mag_l > mag_r ? mag_l : mag_r);
  wire logic [14:0] mag_lv = mtr_flag ? mag_l : mag_r;
  wire logic [14:0] mag = peak_mode ? mag_pk : mag_lv;
  wire logic mtr_track = sample_valid_i & (peak_mode | level_mode);
  wire logic new_max = mtr_track & (mag > mtr_max);
  wire logic mtr_clear = actrl.meter_mode == AOC_MTR_NORMAL |
                         (wr_audio & next_actrl.mute);
  wire logic lvl_read = level_mode & done_evt;

  // Maximum tracking; level readout clears and swaps channel
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      mtr_max <= 15'h0000;
      mtr_flag <= 1'b1;
    end else if (mtr_clear) begin
      mtr_max <= 15'h0000;
    end else if (lvl_read) begin
      mtr_max <= 15'h0000;
      mtr_flag <= ~mtr_flag;
    end else if (new_max) begin
      mtr_max <= mag;
    end
  end

  // Subcode capture; peak mode keeps absolute time of the maximum
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      q_reg <= {`AOC_Q_BITS{1'b0}};
      abs_hold <= {`AOC_ABS_BITS{1'b0}};
      abs_pend <= 1'b0;
    end else begin
      if (subq_valid_i) begin
        q_reg <= subq_data_i;
      end
      if (new_max && peak_mode) begin
        abs_pend <= 1'b1;
      end else if (subq_valid_i && abs_pend) begin
        abs_pend <= 1'b0;
        abs_hold <= subq_data_i[`AOC_ABS_BITS-1:0];
      end
    end
  end

  wire logic [`AOC_Q_BITS-1:0] q_view = peak_mode ?
      {q_reg[`AOC_Q_BITS-1:`AOC_ABS_BITS], abs_hold} : q_reg;
  wire logic flag_view = peak_mode ? 1'b0 : mtr_flag;

  // Readout word, frozen while the link is shifting
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      snap <= {`AOC_READ_BITS{1'b0}};
    end else if (!stab[S_BUSY]) begin
      snap <= {q_view, rev15(mtr_max), flag_view};
    end
  end

  // Mute state and static settings shown on pins
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      mute_active_o <= 1'b0;
      c2_double_corr_o <= 1'b0;
      crystal_rate_select_o <= 1'b0;
    end else begin
      mute_active_o <= out_mute;
      c2_double_corr_o <= actrl.meter_mode[1];
      crystal_rate_select_o <= actrl.crystal_rate_select;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Readout link domain

  logic lclk;
  logic [2:0] lrst_sy;
  logic [6:0] lcnt;
  logic [`AOC_READ_BITS-1:0] lsh;

  // Source is switched only while both clocks idle high
  assign lclk = actrl.sense_output_source ? sense_readout_clock_i :
                subcode_readout_clock_i;

  // Reset brought into the link domain
  always_ff @(negedge lclk) begin
    lrst_sy <= {lrst_sy[1:0], sys_rst_i};
  end

  wire logic lrst = lrst_sy[2] & lrst_sy[1];
  wire logic llast = lcnt == 7'(`AOC_READ_BITS - 1);

  // One bit per falling edge; word taken at the first edge
  always_ff @(negedge lclk) begin
    if (lrst) begin
      lcnt <= 7'h00;
      lbusy <= 1'b0;
      done_tgl <= 1'b0;
      lsh <= {`AOC_READ_BITS{1'b0}};
      subcode_serial_out_o <= 1'b0;
    end else begin
      lbusy <= !llast;
      if (lcnt == 7'h00) begin
        lsh <= {snap[`AOC_READ_BITS-2:0], 1'b0};
        subcode_serial_out_o <= snap[`AOC_READ_BITS-1];
      end else begin
        lsh <= {lsh[`AOC_READ_BITS-2:0], 1'b0};
        subcode_serial_out_o <= lsh[`AOC_READ_BITS-1];
      end
      if (llast) begin
        lcnt <= 7'h00;
        done_tgl <= ~done_tgl;
      end else begin
        lcnt <= lcnt + 7'h01;
      end
    end
  end

  // Sense pin carries readout data when selected
  assign sense_monitor_out_o = actrl.sense_output_source ?
      subcode_serial_out_o : sense_status_i;

endmodule
`default_nettype wire

/* File: rtl/aoc_regs.svh */
/*
  Constants of the audio output control block: command addresses,
  command bit positions, reset values, timing and readout layout.
  Assumes a 100 MHz core clock and 28-bit command words (address
  nibble followed by data bits D23 to D0).
*/
`ifndef AOC_REGS_SVH
`define AOC_REGS_SVH

// Command word layout
`define AOC_CMD_BITS 28
`define AOC_ADDR_MSB 27
`define AOC_ADDR_LSB 24
`define AOC_ADDR_MODE 4'h9
`define AOC_ADDR_AUDIO 4'hA

// Audio control command bits
`define AOC_BIT_MUTE 21
`define AOC_BIT_CUT 20
`define AOC_BIT_MSEL_HI 19
`define AOC_BIT_MSEL_LO 18
`define AOC_BIT_XTAL 17
`define AOC_BIT_SENSE 16
`define AOC_ATT1_MSB 15
`define AOC_ATT1_LSB 8
`define AOC_ATT2_MSB 7
`define AOC_ATT2_LSB 0

// Mode command bits
`define AOC_BIT_BILI_MAIN 19
`define AOC_BIT_BILI_SUB 18
`define AOC_BIT_COMMON_ATT 14
`define AOC_PLM_CH2_MSB 11
`define AOC_PLM_CH2_LSB 10
`define AOC_PLM_CH1_MSB 9
`define AOC_PLM_CH1_LSB 8

// Reset values
`define AOC_ATT_RESET 8'hFF
`define AOC_ROUTE_CH1_RESET 2'h1
`define AOC_ROUTE_CH2_RESET 2'h2

// Timing
`define AOC_CLK_KHZ 100000
`define AOC_GFS_MS 35
`define AOC_ZC_MS 1

// Attenuator ramp: level = code * scale, one step per sample
`define AOC_LVL_SCALE 18'h00404
`define AOC_LVL_STEP 19'h00100
`define AOC_LVL_FULL 18'h3FFFC
`define AOC_LVL_FRAC 18
`define AOC_CUT_SHIFT 2

// Readout layout
`define AOC_READ_BITS 96
`define AOC_Q_BITS 80
`define AOC_ABS_BITS 24
`define AOC_PCM_MAX 15'h7FFF

`endif

/* File: rtl/aoc_pkg.sv */
/*
  Types of the audio output control block.
  Assumes the constants header is used alongside for numbers.
*/
package aoc_pkg;

  typedef enum logic [1:0] {
    AOC_RT_MUTE  = 2'b00,
    AOC_RT_LEFT  = 2'b01,
    AOC_RT_RIGHT = 2'b10,
    AOC_RT_SUM   = 2'b11
  } aoc_route_t;

  typedef enum logic [1:0] {
    AOC_MTR_NORMAL = 2'b00,
    AOC_MTR_LEVEL  = 2'b01,
    AOC_MTR_PEAK   = 2'b10,
    AOC_MTR_LOWC2  = 2'b11
  } aoc_meter_t;

  typedef enum logic [1:0] {
    AOC_ZC_OPEN    = 2'b00,
    AOC_ZC_MUTING  = 2'b01,
    AOC_ZC_MUTED   = 2'b10,
    AOC_ZC_RELEASE = 2'b11
  } aoc_zc_t;

  typedef struct packed {
    logic mute;
    logic fixed_cut_select;
    aoc_meter_t meter_mode;
    logic crystal_rate_select;
    logic sense_output_source;
    logic [7:0] channel1_atten_data;
    logic [7:0] channel2_atten_data;
  } aoc_audio_ctrl_t;

  typedef struct packed {
    logic bilingual_main_select;
    logic bilingual_sub_select;
    logic common_atten_select;
    aoc_route_t ch2;
    aoc_route_t ch1;
  } aoc_mode_ctrl_t;

  typedef struct packed {
    logic signed [15:0] left;
    logic signed [15:0] right;
  } aoc_stereo_t;

  typedef struct packed {
    logic signed [15:0] ch1;
    logic signed [15:0] ch2;
  } aoc_dac_t;

endpackage

/* File: testbench/aoc_audio_out_chk.sv */
/* Port assertions for the audio output block.
   Assumes one core clock domain with synchronous reset. */
`timescale 1ns/1ps
`default_nettype none
module aoc_audio_out_chk #(
  parameter int unsigned ZC_CYCLES = 50
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic cmd_latch_i,
  input wire logic mute_pin_i,
  input wire logic sample_valid_i,
  input wire aoc_pkg::aoc_dac_t dac_o,
  input wire logic dac_valid_o,
  input wire logic mute_active_o,
  input wire logic c2_double_corr_o,
  input wire logic crystal_rate_select_o
);
  import aoc_pkg::*;
  localparam int ZC_LIM = ZC_CYCLES + 12;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (sys_rst_i);
  ////////////////////
  // Pin held long enough to pass its input filter
  sequence s_pin_held;
    mute_pin_i [*8];
  endsequence
  // Mute timing and hold
  a_pin_mutes: assert property (
    s_pin_held |-> ##[0:ZC_LIM] mute_active_o) else $error("pin mute late");
  a_pin_holds: assert property (
    mute_pin_i && $past(mute_pin_i, 6) && mute_active_o |=> mute_active_o)
    else $error("mute dropped while pin high");
  a_mute_silent: assert property (
    mute_active_o && $past(mute_active_o) && dac_valid_o |-> dac_o == '0)
    else $error("muted output not zero");
  // Output strobe tied to input strobe
  a_valid_next: assert property (
    sample_valid_i |=> dac_valid_o) else $error("no output strobe");
  a_valid_cause: assert property (
    dac_valid_o |-> $past(sample_valid_i)) else $error("stray strobe");
  a_dac_holds: assert property (
    !dac_valid_o |-> $stable(dac_o)) else $error("output moved unstrobed");
  // Settings move only while a completed word is latched
  a_xtal_latched: assert property (
    $changed(crystal_rate_select_o) |-> cmd_latch_i)
    else $error("crystal bit moved without latch");
  a_c2_latched: assert property (
    $changed(c2_double_corr_o) |-> cmd_latch_i)
    else $error("correction level moved without latch");
endmodule
`default_nettype wire

/* File: testbench/aoc_host_model.sv */
/* Host model: serial command words and meter readouts.
   Assumes pins are filtered by a 100 MHz core clock. */
`timescale 1ns/1ps
`default_nettype none
module aoc_host_model (
  output logic cmd_clk_o,
  output logic cmd_data_o,
  output logic cmd_latch_o,
  output logic subcode_readout_clock_o,
  output logic sense_readout_clock_o,
  input wire logic serial_i
);
  // Readout clocks idle high, so source switching between readouts is safe
  initial begin
    cmd_clk_o = 1'b0;
    cmd_data_o = 1'b0;
    cmd_latch_o = 1'b0;
    subcode_readout_clock_o = 1'b1;
    sense_readout_clock_o = 1'b1;
  end
  ////////////////////
  // Half a link period low, then back high
  task automatic tick();
    subcode_readout_clock_o = 1'b0;
    #62.5 subcode_readout_clock_o = 1'b1;
  endtask
  // Whole 28-bit word, address first, then latch rise
  task automatic send_word(input logic [3:0] a, input logic [23:0] d);
    logic [27:0] w;
    w = {a, d};
    cmd_latch_o = 1'b0;
    for (int i = 27; i >= 0; i--) begin
      #50 cmd_data_o = w[i];
      #50 cmd_clk_o = 1'b1;
      #50 cmd_clk_o = 1'b0;
    end
    #50 cmd_data_o = ~w[0];
    cmd_latch_o = 1'b1;
    #100;
  endtask
  // Exactly 96 clocks; frame bit k lands in q[k]
  task automatic read_out(output logic [95:0] q);
    for (int i = 0; i < 96; i++) begin
      tick();
      q[i] = serial_i;
      #62.5;
    end
    #1200;
  endtask
endmodule
`default_nettype wire

/* File: testbench/tb_audio_output_control.sv */
/* Self-checking bench for the audio output block.
   Assumes the host model and checker are compiled before it. */
`timescale 1ns/1ps
`default_nettype none
`include "aoc_regs.svh"
module tb_audio_output_control;
  import aoc_pkg::*;
  localparam logic XTAL = 1'b1; // 16.9344 MHz crystal fitted
  logic core_clk_i = 1'b0, sys_rst_i = 1'b1, mute_pin_i = 1'b0;
  logic dout_mute_flag_i = 1'b0, frame_sync_good_i = 1'b1;
  logic sample_valid_i, sample_interp_i, subq_valid_i, sense_status_i;
  logic dac_valid_o, mute_active_o, c2_double_corr_o, crystal_rate_select_o;
  logic subcode_serial_out_o, sense_monitor_out_o;
  logic cmd_clk, cmd_data, cmd_latch, sq_clk, se_clk;
  aoc_stereo_t sample_i;
  aoc_dac_t dac_o;
  aoc_dac_t exp_q[$];
  logic [79:0] subq_data_i, qa, qb;
  logic [95:0] q;
  logic signed [15:0] l, r;
  int error_cnt = 0, tests_run = 0, seed = 80576;

  always #5 core_clk_i = ~core_clk_i;

  aoc_host_model h (.cmd_clk_o(cmd_clk), .cmd_data_o(cmd_data),
    .cmd_latch_o(cmd_latch), .subcode_readout_clock_o(sq_clk),
    .sense_readout_clock_o(se_clk), .serial_i(subcode_serial_out_o));
  aoc_audio_out #(.GFS_CYCLES(200), .ZC_CYCLES(50)) dut (.core_clk_i,
    .sys_rst_i, .cmd_clk_i(cmd_clk), .cmd_data_i(cmd_data),
    .cmd_latch_i(cmd_latch), .mute_pin_i, .digital_out_enable_pin_i(1'b1),
    .frame_sync_good_i, .dout_mute_flag_i, .normal_speed_i(1'b1),
    .sample_valid_i, .sample_i, .sample_interp_i, .subq_valid_i,
    .subq_data_i, .sense_status_i, .subcode_readout_clock_i(sq_clk),
    .sense_readout_clock_i(se_clk), .dac_o, .dac_valid_o, .mute_active_o,
    .c2_double_corr_o, .crystal_rate_select_o, .subcode_serial_out_o,
    .sense_monitor_out_o);
  ////////////////////
  // Compare, count, report
  task chk(input logic [95:0] g, input logic [95:0] e);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task stop_test();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Command word images
  function logic [23:0] aw(input logic mu, ct, input logic [1:0] ms,
                           input logic [7:0] a1, a2);
    return {2'b00, mu, ct, ms, XTAL, 1'b0, a1, a2};
  endfunction
  function logic [23:0] mw(input logic bm, bs, cm, input logic [3:0] p);
    return {4'h0, bm, bs, 3'h0, cm, 2'h0, p, 8'h00};
  endfunction
  // Expected channel for a route code
  function logic [15:0] rt(input logic [1:0] c);
    logic signed [16:0] s;
    s = l + r;
    return c == 2'h0 ? 16'h0000 : c == 2'h1 ? l : c == 2'h2 ? r : s[16:1];
  endfunction
  // One sample in, its expected output noted
  task put(input aoc_dac_t e, input logic ip);
    exp_q.push_back(e);
    @(posedge core_clk_i) #1;
    sample_valid_i = 1'b1;
    sample_i = {l, r};
    sample_interp_i = ip;
    sense_status_i = 1'($random(seed));
    @(posedge core_clk_i) #1;
    sample_valid_i = 1'b0;
    chk(sense_monitor_out_o, sense_status_i);
    repeat (2) @(posedge core_clk_i);
    #1;
  endtask
  task wm(input logic v);
    for (int n = 0; n < 500 && mute_active_o !== v; n++)
      @(posedge core_clk_i) #1;
    chk(mute_active_o, v);
    if (mute_active_o !== v) stop_test();
  endtask
  task sq(input logic [79:0] d);
    @(posedge core_clk_i) #1;
    subq_valid_i = 1'b1;
    subq_data_i = d;
    @(posedge core_clk_i) #1;
    subq_valid_i = 1'b0;
  endtask
  task rd(input logic f, input logic [14:0] p, input logic [79:0] qe);
    logic [79:0] rq;
    rq = {<<{qe}};
    h.read_out(q);
    chk(q, {f, p, rq});
  endtask
  // Output watcher takes the oldest note per strobe
  always @(negedge core_clk_i)
    if (dac_valid_o === 1'b1)
      chk(dac_o, exp_q.size() > 0 ? 32'(exp_q.pop_front()) : 'x);
  initial begin
    #1000000;
    error_cnt++;
    stop_test();
  end
  ////////////////////
  // Main sequence
  initial begin
    {sample_valid_i, sample_interp_i, subq_valid_i, sense_status_i} = '0;
    sample_i = '0;
    subq_data_i = '0;
    repeat (5) begin
      h.tick();
      #62.5;
    end
    repeat (20) @(posedge core_clk_i);
    #1 sys_rst_i = 1'b0;
    repeat (2) begin
      h.tick();
      #62.5;
    end
    h.read_out(q);
    chk({c2_double_corr_o, mute_active_o, crystal_rate_select_o}, 3'h0);
    l = 16'($random(seed) & 32'hFFFE);
    r = 16'($random(seed) & 32'hFFFE);
    put({l, r}, 1'b0);
    h.send_word(`AOC_ADDR_AUDIO, aw(0, 0, 2'h0, 8'hFF, 8'hFF));
    chk(crystal_rate_select_o, XTAL);
    for (int m = 0; m < 16; m++) begin
      l = 16'($random(seed) & 32'hFFFE);
      r = 16'($random(seed) & 32'hFFFE);
      h.send_word(`AOC_ADDR_MODE, mw(0, 0, 0, 4'(m)));
      put({rt(m[1:0]), rt(m[3:2])}, 1'b0);
    end
    h.send_word(`AOC_ADDR_MODE, mw(0, 0, 1, 4'h9));
    h.send_word(`AOC_ADDR_AUDIO, aw(0, 1, 2'h0, 8'hFF, 8'h00));
    put({l >>> 2, r >>> 2}, 1'b0);
    h.send_word(`AOC_ADDR_AUDIO, aw(0, 0, 2'h0, 8'hFF, 8'hFF));
    h.send_word(`AOC_ADDR_MODE, mw(0, 0, 0, 4'h9));
    for (int k = 0; k < 3; k++) begin
      {mute_pin_i, dout_mute_flag_i, frame_sync_good_i} =
        k == 0 ? 3'b101 : k == 1 ? 3'b011 : 3'b000;
      wm(1'b1);
      put('0, 1'b0);
      {mute_pin_i, dout_mute_flag_i, frame_sync_good_i} = 3'b001;
      wm(1'b0);
    end
    h.send_word(`AOC_ADDR_MODE, mw(1, 1, 0, 4'h9));
    wm(1'b1);
    h.send_word(`AOC_ADDR_MODE, mw(0, 0, 0, 4'h9));
    wm(1'b0);
    h.send_word(`AOC_ADDR_AUDIO, aw(1, 0, 2'h0, 8'hFF, 8'hFF));
    wm(1'b1);
    h.send_word(`AOC_ADDR_AUDIO, aw(0, 0, 2'h1, 8'hFF, 8'hFF));
    wm(1'b0);
    chk(c2_double_corr_o, 1'b0);
    h.read_out(q);
    qa = 80'({$random(seed), $random(seed), $random(seed)});
    qb = 80'({$random(seed), $random(seed), $random(seed)});
    sq(qa);
    l = 16'sd3000;
    r = -16'sd1234;
    put({l, r}, 1'b0);
    l = 16'sd20000;
    r = 16'sd500;
    put({l, r}, 1'b0);
    rd(1'b0, 15'd1234, qa);
    l = -16'sd700;
    r = 16'sd9000;
    put({l, r}, 1'b0);
    rd(1'b1, 15'd700, qa);
    h.send_word(`AOC_ADDR_AUDIO, aw(1, 0, 2'h2, 8'hFF, 8'hFF));
    h.send_word(`AOC_ADDR_AUDIO, aw(0, 0, 2'h2, 8'hFF, 8'hFF));
    wm(1'b1);
    chk(c2_double_corr_o, 1'b1);
    l = -16'sd5000;
    r = 16'sd2000;
    put('0, 1'b0);
    sq(qa);
    sq(qb);
    l = 16'sd30000;
    r = -16'sd30000;
    put('0, 1'b1);
    rd(1'b0, 15'd5000, {qb[79:24], qa[23:0]});
    rd(1'b0, 15'd5000, {qb[79:24], qa[23:0]});
    h.send_word(`AOC_ADDR_AUDIO, aw(0, 0, 2'h3, 8'hFF, 8'hFF));
    wm(1'b0);
    chk(c2_double_corr_o, 1'b1);
    stop_test();
  end
endmodule

// Checker beside the block's ports
bind aoc_audio_out aoc_audio_out_chk #(.ZC_CYCLES(ZC_CYCLES)) u_chk (
  .core_clk_i, .sys_rst_i, .cmd_latch_i, .mute_pin_i, .sample_valid_i,
  .dac_o, .dac_valid_o, .mute_active_o, .c2_double_corr_o,
  .crystal_rate_select_o);
`default_nettype wire
